// ==== logic/sdt_test_regs.sv ====
// Diagnostic test registers of the SCSI/DMA core pair, an AHB-Lite slave.
// Assumes one clock, core-side inputs on that clock and SCSI pins from outside it.
// Behaviour
// R01: Status bit mirrors internal request line.
// R02: Status bit mirrors active-low acknowledge line.
// R03: FIFO read pops byte, latches parity.
// R04: Empty FIFO read raises gross error.
// R05: Global tristate floats outputs and read data.
// R06: SCSI tristate floats pins, directions low.
// R07: Loopback routes output latch into input.
// R08: Output latch write pushes FIFO with parity.
// R09: Lane field gates DMA FIFO access.
// R10: Address step increments pointer once, clears.
// R11: Count step decrements counter once, clears.
// R12: Offset clear self-clears, set on error.
// R13: Master bit sets force polarity.
// R14: Direction force drives write direction.
// R15: End force pulses, then self-clears.
// R16: Request force clears once request asserted.
// R17: Acknowledge force clears once acknowledge asserted.
// R18: Lane writes push top, reads pop bottom.
// R19: Lane write stores parity source bit.
// R20: Even mode inverts parity both ways.
// R21: Hint bit drives data/code low on fetch.
// R22: Data/code high on every data move.
// R23: Reserved bits read zero, ignore writes.
//
// The implementer's own choice: the AHB-Lite register port.
`include "sdt_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sdt_test_regs
  import sdt_pkg::*;
#(
  parameter int SF_DEPTH = 8,
  parameter int DF_DEPTH = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire sdt_hs_s core_hs_in,
  output var sdt_hs_s core_hs,
  input wire logic [8:0] scsi_pin_in,
  input wire logic scsi_latch_strobe,
  input wire logic scsi_drive_req,
  input wire logic [11:0] scsi_dir_req,
  input wire logic scsi_even_parity_assert,
  input wire logic host_parity_in,
  input wire logic host_bus_wide,
  input wire logic host_drive_req,
  input wire logic instr_fetch,
  output logic [8:0] scsi_pin_out,
  output logic scsi_pin_oe,
  output logic [11:0] scsi_dir,
  output logic host_parity_out,
  output logic host_par_to_scsi,
  output logic host_drive_oe,
  output logic instr_cache_hint_n,
  output logic loopback_enable,
  output logic scsi_gross_error,
  output logic offset_counter_clear
);
  localparam int SFW = $clog2(SF_DEPTH);
  localparam int DFW = $clog2(DF_DEPTH);

  // The pointers wrap naturally, so only powers of two are served.
  initial begin
    if (SF_DEPTH < 2 || (1 << SFW) != SF_DEPTH || DF_DEPTH < 2 || (1 << DFW) != DF_DEPTH) begin
      $error("sdt_test_regs: FIFO depths must be powers of two of at least two");
    end
  end

  // Odd parity unless the even request is given.
  function automatic logic par_of(input logic [7:0] d, input logic even);
    par_of = (^d) ^ ~even;
  endfunction

  // Pointer step: up to the next bus-width boundary.
  function automatic logic [2:0] inc_amt(input logic [1:0] a, input logic wide);
    inc_amt = wide ? (3'h4 - {1'b0, a}) : (a[0] ? 3'h1 : 3'h2);
  endfunction

  // Counter step: one bus width, never past zero.
  function automatic logic [2:0] dec_amt(input logic [23:0] c, input logic wide);
    logic [2:0] lim;
    lim = wide ? 3'h4 : 3'h2;
    dec_amt = (c < {21'h0, lim}) ? c[2:0] : lim;
  endfunction

  logic [7:0] c4_r, c5_r, c7_r, c5_nxt;
  logic sfp_r, dfp_r;
  sdt_hs_s hs_r, hs_nxt;
  logic [31:0] nadr_r, hrdata_r;
  logic [23:0] bcnt_r;
  sdt_ent_s olat_r, ilat_r;
  logic wr_pend_r;
  logic [7:0] wr_idx_r;
  logic [8:0] s1_r, s2_r, s3_r, pin_r;
  logic [8:0] pout_r;
  logic poe_r, hpar_r, hpar_scsi_r, hoe_r, hint_n_r, gross_r, oclr_r;
  logic [11:0] dir_r;
  sdt_ent_s sf_mem [SF_DEPTH];
  logic [SFW-1:0] sf_rp_r, sf_wp_r;
  logic [SFW:0] sf_cnt_r;
  sdt_ent_s df_mem [4][DF_DEPTH];
  logic [DFW-1:0] df_rp_r [4];
  logic [DFW-1:0] df_wp_r [4];
  logic [DFW:0] df_cnt_r [4];

  // Address phase decode; the slave never stalls, so every phase is one cycle.
  wire addr_ok = hsel & htrans[1] & hready;
  wire in_map = (haddr[31:10] == 22'h0);
  wire [7:0] aidx = haddr[9:2];
  wire rd_go = addr_ok & ~hwrite & in_map;
  wire wr_go = addr_ok & hwrite & in_map;
  wire [7:0] wd = hwdata[7:0];
  wire wr_c4 = wr_pend_r & (wr_idx_r == `SDT_IDX_C4);
  wire wr_c5 = wr_pend_r & (wr_idx_r == `SDT_IDX_C5);
  wire wr_c6 = wr_pend_r & (wr_idx_r == `SDT_IDX_C6);
  wire wr_c7 = wr_pend_r & (wr_idx_r == `SDT_IDX_C7);
  wire wr_olat = wr_pend_r & (wr_idx_r == `SDT_IDX_OLAT);
  wire wr_nadr = wr_pend_r & (wr_idx_r == `SDT_IDX_NADR);
  wire wr_bcnt = wr_pend_r & (wr_idx_r == `SDT_IDX_BCNT);
  wire rd_c3 = rd_go & (aidx == `SDT_IDX_C3);
  wire rd_c6 = rd_go & (aidx == `SDT_IDX_C6);

  // Control fields.
  wire gtri = c4_r[`SDT_C4_GTRI];
  wire stri = c4_r[`SDT_C4_STRI];
  wire loop = c4_r[`SDT_C4_LOOP];
  wire force_polarity_master = c5_r[`SDT_C5_FORCE_POLARITY_MASTER];
  wire lane_en = c4_r[`SDT_C4_LANE_EN]; // [R09]
  wire [1:0] lane = c4_r[1:0]; // [R09]
  wire even_parity_select = c7_r[`SDT_C7_EVP];

  // SCSI FIFO traffic; a push into a full FIFO is dropped.
  wire sf_empty = (sf_cnt_r == '0);
  wire sf_full = (sf_cnt_r == (SFW+1)'(SF_DEPTH));
  wire sf_push = wr_olat & c4_r[`SDT_C4_SFWE] & ~sf_full; // [R08]
  wire sf_pop = rd_c3 & ~sf_empty; // [R03]
  wire sf_under = rd_c3 & sf_empty; // [R04]
  wire sdt_ent_s sf_bot = sf_mem[sf_rp_r];
  wire [7:0] olat_par_src = wd;

  // DMA FIFO lane traffic, only with the lane field enabled.
  wire df_empty = (df_cnt_r[lane] == '0);
  wire df_full = (df_cnt_r[lane] == (DFW+1)'(DF_DEPTH));
  wire df_push = wr_c6 & lane_en & ~df_full; // [R09] [R18]
  wire df_pop = rd_c6 & lane_en & ~df_empty; // [R09] [R18]
  wire sdt_ent_s df_bot = df_mem[lane][df_rp_r[lane]];

  // Read multiplexer; reserved bits and unmapped words read zero.
  wire [7:0] stat2 = {3'h0, sfp_r, dfp_r, 1'b0, hs_r.req, hs_r.ack_n}; // [R01] [R02] [R23]
  wire [31:0] rd_mux =
    (aidx == `SDT_IDX_STAT2) ? {24'h0, stat2} :
    (aidx == `SDT_IDX_C3) ? {24'h0, sf_empty ? 8'h00 : sf_bot.data} :
    (aidx == `SDT_IDX_C4) ? {24'h0, c4_r} :
    (aidx == `SDT_IDX_C5) ? {24'h0, c5_r} :
    (aidx == `SDT_IDX_C6) ? {24'h0, (lane_en & ~df_empty) ? df_bot.data : 8'h00} :
    (aidx == `SDT_IDX_C7) ? {24'h0, c7_r} :
    (aidx == `SDT_IDX_OLAT) ? {23'h0, olat_r} :
    (aidx == `SDT_IDX_ILAT) ? {23'h0, ilat_r} :
    (aidx == `SDT_IDX_NADR) ? nadr_r :
    (aidx == `SDT_IDX_BCNT) ? {8'h0, bcnt_r} : 32'h0;
  wire [31:0] hrdata_nxt = (rd_go & ~gtri) ? rd_mux : 32'h0; // [R05]

  // Step amounts for the pointer and the counter.
  wire [2:0] nadr_inc = inc_amt(nadr_r[1:0], host_bus_wide);
  wire [2:0] bcnt_dec = dec_amt(bcnt_r, host_bus_wide);

  // Force bits: end, request and acknowledge self-clear in assert polarity; direction always holds, as all do in deassert polarity.
  always_comb begin
    c5_nxt = c5_r;
    c5_nxt[`SDT_C5_ASTEP] = 1'b0; // [R10]
    c5_nxt[`SDT_C5_CSTEP] = 1'b0; // [R11]
    c5_nxt[`SDT_C5_OCLR] = 1'b0; // [R12]
    if (force_polarity_master & c5_r[`SDT_C5_EOP]) begin
      c5_nxt[`SDT_C5_EOP] = 1'b0; // [R15]
    end
    if (force_polarity_master & c5_r[`SDT_C5_REQ] & hs_r.req) begin
      c5_nxt[`SDT_C5_REQ] = 1'b0; // [R16]
    end
    if (force_polarity_master & c5_r[`SDT_C5_ACK] & ~hs_r.ack_n) begin
      c5_nxt[`SDT_C5_ACK] = 1'b0; // [R17]
    end
    if (wr_c5) begin
      c5_nxt = wd;
    end
    if (sf_under) begin
      c5_nxt[`SDT_C5_OCLR] = 1'b1; // [R12]
    end
  end

  // A set force bit overrides the core line, or the held value for direction; the master bit picks the level.
  always_comb begin
    hs_nxt.req = c5_r[`SDT_C5_REQ] ? force_polarity_master : core_hs_in.req; // [R13] [R16]
    hs_nxt.ack_n = c5_r[`SDT_C5_ACK] ? ~force_polarity_master : core_hs_in.ack_n; // [R13] [R17]
    hs_nxt.eop = c5_r[`SDT_C5_EOP] ? force_polarity_master : core_hs_in.eop; // [R13] [R15]
    hs_nxt.dir = c5_r[`SDT_C5_DIR] ? force_polarity_master : hs_r.dir; // [R13] [R14]
  end

  // Bus slave state: read data is registered in the address phase.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= `SDT_RST8;
      hrdata_r <= 32'h0;
    end else begin
      wr_pend_r <= wr_go;
      wr_idx_r <= aidx;
      hrdata_r <= hrdata_nxt;
    end
  end

  // Control registers; reserved bits never store.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      c4_r <= `SDT_RST8;
      c5_r <= `SDT_RST8;
      c7_r <= `SDT_RST8;
      hs_r <= '0;
    end else begin
      c4_r <= wr_c4 ? (wd & `SDT_C4_MASK) : c4_r; // [R23]
      c7_r <= wr_c7 ? (wd & `SDT_C7_MASK) : c7_r; // [R23]
      c5_r <= c5_nxt;
      hs_r <= hs_nxt;
    end
  end

  // Pointer and counter, stepped once per step request.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      nadr_r <= 32'h0;
      bcnt_r <= 24'h0;
    end else begin
      if (wr_nadr) begin
        nadr_r <= hwdata;
      end else if (c5_r[`SDT_C5_ASTEP]) begin
        nadr_r <= nadr_r + {29'h0, nadr_inc}; // [R10]
      end
      if (wr_bcnt) begin
        bcnt_r <= hwdata[23:0];
      end else if (c5_r[`SDT_C5_CSTEP]) begin
        bcnt_r <= bcnt_r - {21'h0, bcnt_dec}; // [R11]
      end
    end
  end

  // SCSI FIFO storage; the parity of each popped byte is latched for status.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sf_rp_r <= '0;
      sf_wp_r <= '0;
      sf_cnt_r <= '0;
      sfp_r <= 1'b0;
    end else begin
      if (sf_push) begin
        sf_mem[sf_wp_r] <= '{par: par_of(olat_par_src, scsi_even_parity_assert), data: wd}; // [R08]
        sf_wp_r <= sf_wp_r + 1'b1;
      end
      if (sf_pop) begin
        sf_rp_r <= sf_rp_r + 1'b1;
        sfp_r <= sf_bot.par; // [R03]
      end
      sf_cnt_r <= sf_cnt_r + (SFW+1)'(sf_push) - (SFW+1)'(sf_pop);
    end
  end

  // DMA FIFO lanes; a written byte takes the parity source bit as its parity.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        df_rp_r[i] <= '0;
        df_wp_r[i] <= '0;
        df_cnt_r[i] <= '0;
      end
      dfp_r <= 1'b0;
    end else begin
      if (df_push) begin
        df_mem[lane][df_wp_r[lane]] <= '{par: c7_r[`SDT_C7_DFP], data: wd}; // [R18] [R19]
        df_wp_r[lane] <= df_wp_r[lane] + 1'b1;
      end
      if (df_pop) begin
        df_rp_r[lane] <= df_rp_r[lane] + 1'b1;
        dfp_r <= df_bot.par; // [R18]
      end
      df_cnt_r[lane] <= df_cnt_r[lane] + (DFW+1)'(df_push) - (DFW+1)'(df_pop);
    end
  end

  // SCSI pins are asynchronous; a change counts once the later two stages agree.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_r <= 9'h000;
      s2_r <= 9'h000;
      s3_r <= 9'h000;
      pin_r <= 9'h000;
    end else begin
      s1_r <= scsi_pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_r <= (s2_r == s3_r) ? s3_r : pin_r;
    end
  end

  // Output and input latches; loopback feeds the output byte straight back.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      olat_r <= '0;
      ilat_r <= '0;
    end else begin
      if (wr_olat) begin
        olat_r <= '{par: par_of(wd, scsi_even_parity_assert), data: wd};
      end
      if (loop & wr_olat) begin
        ilat_r <= '{par: par_of(wd, scsi_even_parity_assert), data: wd}; // [R07]
      end else if (~loop & scsi_latch_strobe) begin
        ilat_r <= pin_r;
      end
    end
  end

  // Pin drivers; every one is registered so the tristate modes take effect together.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pout_r <= 9'h000;
      poe_r <= 1'b0;
      dir_r <= 12'h000;
      hpar_r <= 1'b0;
      hpar_scsi_r <= 1'b0;
      hoe_r <= 1'b0;
      hint_n_r <= 1'b1;
      gross_r <= 1'b0;
      oclr_r <= 1'b0;
    end else begin
      pout_r <= olat_r;
      poe_r <= ~gtri & ~stri & (scsi_drive_req | loop); // [R05] [R06] [R07]
      dir_r <= (gtri | stri) ? 12'h000 : scsi_dir_req; // [R06]
      hpar_r <= pin_r[8] ^ even_parity_select; // [R20]
      hpar_scsi_r <= host_parity_in ^ even_parity_select; // [R20]
      hoe_r <= ~gtri & host_drive_req; // [R05]
      hint_n_r <= ~(instr_fetch & c7_r[`SDT_C7_HINT]); // [R21] [R22]
      gross_r <= sf_under; // [R04]
      oclr_r <= c5_r[`SDT_C5_OCLR]; // [R12]
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign core_hs = hs_r;
  assign scsi_pin_out = pout_r;
  assign scsi_pin_oe = poe_r;
  assign scsi_dir = dir_r;
  assign host_parity_out = hpar_r;
  assign host_par_to_scsi = hpar_scsi_r;
  assign host_drive_oe = hoe_r;
  assign instr_cache_hint_n = hint_n_r;
  assign loopback_enable = loop;
  assign scsi_gross_error = gross_r;
  assign offset_counter_clear = oclr_r;

  // Checks on the externally visible behaviour and on internal state: SCSI FIFO count and parity, input latch, control register 5 and pointer.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  req_mirror_a: assert property ( // [R01]
    rd_go && aidx == `SDT_IDX_STAT2 && !gtri |=> hrdata[1] == $past(hs_r.req))
    else $error("request status bit does not mirror the line");
  ack_mirror_a: assert property ( // [R02]
    rd_go && aidx == `SDT_IDX_STAT2 && !gtri |=> hrdata[0] == $past(hs_r.ack_n))
    else $error("acknowledge status bit does not mirror the line");
  fifo_pop_a: assert property ( // [R03]
    sf_pop && !sf_push |=> sf_cnt_r == $past(sf_cnt_r) - 1'b1 && sfp_r == $past(sf_bot.par))
    else $error("SCSI FIFO pop lost count or parity");
  underflow_err_a: assert property ( // [R04]
    rd_c3 && sf_empty |=> scsi_gross_error ##1 offset_counter_clear)
    else $error("FIFO underflow did not raise gross error and offset clear");
  gtri_rdata_a: assert property ( // [R05]
    rd_go && gtri |=> hrdata == 32'h0 && !host_drive_oe)
    else $error("read data driven under global tristate");
  stri_pins_a: assert property ( // [R06]
    stri |=> !scsi_pin_oe && scsi_dir == 12'h000)
    else $error("SCSI pins driven under SCSI tristate");
  loop_route_a: assert property ( // [R07]
    wr_olat && loop |=> ilat_r.data == $past(hwdata[7:0]))
    else $error("loopback byte not routed to input latch");
  eop_pulse_a: assert property ( // [R15]
    wr_c5 && wd[`SDT_C5_EOP] && wd[`SDT_C5_FORCE_POLARITY_MASTER] |=> c5_r[`SDT_C5_EOP] ##1 (hs_r.eop && !c5_r[`SDT_C5_EOP]))
    else $error("end force did not pulse and self-clear");
  addr_step_a: assert property ( // [R10]
    c5_r[`SDT_C5_ASTEP] && !wr_nadr && !wr_c5 |=> nadr_r == $past(nadr_r) + $past(nadr_inc) && !c5_r[`SDT_C5_ASTEP])
    else $error("address step wrong or repeated");
  hint_data_a: assert property ( // [R22]
    !instr_fetch |=> instr_cache_hint_n)
    else $error("data/code low outside an instruction fetch");

  fifo_pop_c: cover property (sf_pop ##1 sf_empty);
  underflow_c: cover property (sf_under);
  lane_push_c: cover property (df_push ##[1:8] df_pop);
  eop_force_c: cover property (hs_r.eop && force_polarity_master);

endmodule // sdt_test_regs

`default_nettype wire

// ==== common/sdt_defines.svh ====
// Register indices, field positions and reset values of the test register block.
// Assumes byte addresses are four times the index, one register per aligned word.
`ifndef SDT_DEFINES_SVH
`define SDT_DEFINES_SVH
`define SDT_IDX_STAT2 8'h16
`define SDT_IDX_C3 8'h17
`define SDT_IDX_C4 8'h18
`define SDT_IDX_C5 8'h19
`define SDT_IDX_C6 8'h1A
`define SDT_IDX_C7 8'h1B
`define SDT_IDX_OLAT 8'h30
`define SDT_IDX_ILAT 8'h31
`define SDT_IDX_NADR 8'h32
`define SDT_IDX_BCNT 8'h33
`define SDT_C4_GTRI 6
`define SDT_C4_STRI 5
`define SDT_C4_LOOP 4
`define SDT_C4_SFWE 3
`define SDT_C4_LANE_EN 2
`define SDT_C4_MASK 8'h7F
`define SDT_C5_ASTEP 7
`define SDT_C5_CSTEP 6
`define SDT_C5_OCLR 5
`define SDT_C5_FORCE_POLARITY_MASTER 4
`define SDT_C5_DIR 3
`define SDT_C5_EOP 2
`define SDT_C5_REQ 1
`define SDT_C5_ACK 0
`define SDT_C7_DFP 3
`define SDT_C7_EVP 2
`define SDT_C7_HINT 1
`define SDT_C7_MASK 8'h0E
`define SDT_RST8 8'h00
`endif

// ==== common/sdt_pkg.sv ====
// Types shared by the test register block.
// Assumes the defines header is compiled alongside.
package sdt_pkg;
  typedef struct packed {
    logic req;
    logic ack_n;
    logic eop;
    logic dir;
  } sdt_hs_s;
  typedef struct packed {
    logic par;
    logic [7:0] data;
  } sdt_ent_s;
endpackage

// ==== test/sdt_host_model.sv ====
// Host software model: a single-transfer AHB-Lite master for the test registers.
// Assumes one slave whose hreadyout is looped back as hready.
`timescale 1ns/1ps
`default_nettype none

module sdt_host_model (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // One word transfer; called just after a rising edge, returns on the edge that ends the data phase.
  // Ready and read data are taken at the rising edge itself; only the bench timeout ends a wait.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    rd = hrdata;
  endtask
endmodule // sdt_host_model

`default_nettype wire

// ==== test/scsi_dma_chip_test_regs_tb_top.sv ====
// Self-checking bench for the diagnostic test registers.
// Assumes the host model as bus master and the bench acting for the cores and pins.
`timescale 1ns/1ps
`default_nettype none

module scsi_dma_chip_test_regs_tb_top;
  import sdt_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel, hwrite, hready, hresp, scsi_pin_oe, host_parity_out, host_par_to_scsi, host_drive_oe;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  sdt_hs_s hs_in = '0;
  sdt_hs_s hs;
  logic [8:0] pin_in = 9'h0FF;
  logic drv_req = 1'b0, even_as = 1'b0, hpar_in = 1'b0, wide = 1'b1, hdrv_req = 1'b0, fetch = 1'b0;
  logic [11:0] dir_req = 12'h000, scsi_dir;
  logic [8:0] pin_out;
  logic hint_n, loop_en, gross, oclr;
  logic ge_seen = 1'b0, oc_seen = 1'b0, eop_seen = 1'b0, req_seen = 1'b0, ack_seen = 1'b0;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;

  always #2.5 clk = ~clk;

  sdt_host_model sdt_host_model_i (.clk(clk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  sdt_test_regs #(.SF_DEPTH(8), .DF_DEPTH(8)) sdt_test_regs_i (.clk(clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .core_hs_in(hs_in), .core_hs(hs),
    .scsi_pin_in(pin_in), .scsi_latch_strobe(1'b0), .scsi_drive_req(drv_req), .scsi_dir_req(dir_req),
    .scsi_even_parity_assert(even_as), .host_parity_in(hpar_in), .host_bus_wide(wide),
    .host_drive_req(hdrv_req), .instr_fetch(fetch), .scsi_pin_out(pin_out), .scsi_pin_oe(scsi_pin_oe),
    .scsi_dir(scsi_dir), .host_parity_out(host_parity_out), .host_par_to_scsi(host_par_to_scsi),
    .host_drive_oe(host_drive_oe), .instr_cache_hint_n(hint_n), .loopback_enable(loop_en),
    .scsi_gross_error(gross), .offset_counter_clear(oclr));

  // Sticky flags catch one-cycle pulses that a later compare cannot see directly.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (gross === 1'b1) ge_seen <= 1'b1;
    if (oclr === 1'b1) oc_seen <= 1'b1;
    if (hs.eop === 1'b1) eop_seen <= 1'b1;
    if (hs.req === 1'b1) req_seen <= 1'b1;
    if (hs.ack_n === 1'b0) ack_seen <= 1'b1;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    sdt_host_model_i.xfer(1'b1, a, d, rd);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    sdt_host_model_i.xfer(1'b0, a, 32'h0, rd);
    chk(rd, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Reset values, masked fields and an unmapped read.
  task automatic t_regs();
    rdc(32'h60, 32'h0); rdc(32'h64, 32'h0); rdc(32'h6C, 32'h0);
    wr(32'h60, 32'h80); rdc(32'h60, 32'h0);
    wr(32'h6C, 32'hF1); rdc(32'h6C, 32'h0);
    rdc(32'h300, 32'h0);
    chk(hresp, 1'b0);
  endtask

  // Synchronous FIFO fill through the output latch, pops and an underflow.
  task automatic t_sfifo();
    wr(32'h60, 32'h08);
    even_as <= 1'b0; wr(32'hC0, 32'hA5);
    even_as <= 1'b1; wr(32'hC0, 32'h81);
    even_as <= 1'b0; ge_seen <= 1'b0; oc_seen <= 1'b0;
    rdc(32'h5C, 32'hA5); rdc(32'h58, 32'h10);
    rdc(32'h5C, 32'h81); rdc(32'h58, 32'h00);
    rdc(32'h5C, 32'h0); idle(3);
    chk(ge_seen, 1'b1);
    chk(oc_seen, 1'b1);
    rdc(32'h64, 32'h0);
    wr(32'h60, 32'h00);
  endtask

  // Every DMA FIFO lane with alternating parity source, then a disabled access.
  task automatic t_lanes();
    for (int l = 0; l < 4; l++) begin
      wr(32'h60, 32'h04 | l);
      wr(32'h6C, (l % 2) ? 32'h0 : 32'h08);
      wr(32'h68, 32'h11 * (l + 1));
    end
    for (int l = 0; l < 4; l++) begin
      wr(32'h60, 32'h04 | l);
      rdc(32'h68, 32'h11 * (l + 1));
      rdc(32'h58, (l % 2) ? 32'h0 : 32'h08);
    end
    wr(32'h60, 32'h00); wr(32'h68, 32'h77); rdc(32'h68, 32'h0);
    wr(32'h6C, 32'h0);
  endtask

  // Force bits in both polarities, with the status mirror of request and acknowledge.
  task automatic t_force();
    hs_in <= '{req: 1'b0, ack_n: 1'b1, eop: 1'b0, dir: 1'b0};
    eop_seen <= 1'b0; req_seen <= 1'b0; ack_seen <= 1'b0; idle(2);
    wr(32'h64, 32'h14); idle(3); chk(eop_seen, 1'b1); rdc(32'h64, 32'h10);
    wr(32'h64, 32'h12); idle(3); chk(req_seen, 1'b1); rdc(32'h64, 32'h10);
    wr(32'h64, 32'h11); idle(3); chk(ack_seen, 1'b1); rdc(32'h64, 32'h10);
    rdc(32'h58, 32'h01);
    wr(32'h64, 32'h18); idle(2); chk(hs.dir, 1'b1);
    wr(32'h64, 32'h08); idle(2); chk(hs.dir, 1'b0);
    hs_in <= '{req: 1'b1, ack_n: 1'b0, eop: 1'b0, dir: 1'b0}; idle(3);
    rdc(32'h58, 32'h02);
    wr(32'h64, 32'h03); idle(3); chk(hs.req, 1'b0); chk(hs.ack_n, 1'b1);
    rdc(32'h58, 32'h01);
    wr(32'h64, 32'h00); hs_in <= '0;
  endtask

  // Single steps of the address pointer and byte counter on both bus widths.
  task automatic t_step();
    wide <= 1'b1;
    wr(32'hC8, 32'h100); wr(32'hCC, 32'h10);
    wr(32'h64, 32'h80); idle(2); rdc(32'hC8, 32'h104);
    wr(32'h64, 32'h40); idle(2); rdc(32'hCC, 32'h0C);
    wide <= 1'b0;
    wr(32'h64, 32'hC0); idle(2); rdc(32'hC8, 32'h106); rdc(32'hCC, 32'h0A);
    rdc(32'h64, 32'h0);
    wr(32'h64, 32'h20); idle(2); rdc(32'h64, 32'h0);
  endtask

  // Tristate modes, loopback, parity mode and the fetch hint.
  task automatic t_modes();
    hdrv_req <= 1'b1; drv_req <= 1'b1; dir_req <= 12'hFFF;
    wr(32'h60, 32'h40); idle(2); chk(host_drive_oe, 1'b0); rdc(32'h60, 32'h0);
    wr(32'h60, 32'h20); idle(2); chk(host_drive_oe, 1'b1);
    chk(scsi_dir, 12'h000); chk(scsi_pin_oe, 1'b0);
    wr(32'h60, 32'h00); idle(2); chk(scsi_dir, 12'hFFF); chk(scsi_pin_oe, 1'b1);
    wr(32'h60, 32'h10); wr(32'hC0, 32'h5A); idle(3); chk(loop_en, 1'b1);
    sdt_host_model_i.xfer(1'b0, 32'hC4, 32'h0, rd); chk(rd[7:0], 8'h5A);
    chk(pin_out, 9'h15A);
    wr(32'h60, 32'h00);
    hpar_in <= 1'b1; wr(32'h6C, 32'h04); idle(2); chk(host_par_to_scsi, 1'b0);
    chk(host_parity_out, 1'b1);
    wr(32'h6C, 32'h00); idle(2); chk(host_par_to_scsi, 1'b1);
    chk(host_parity_out, 1'b0);
    fetch <= 1'b1; wr(32'h6C, 32'h02); idle(2); chk(hint_n, 1'b0);
    wr(32'h6C, 32'h00); idle(2); chk(hint_n, 1'b1);
    wr(32'h6C, 32'h02); fetch <= 1'b0; idle(2); chk(hint_n, 1'b1);
  endtask

  task automatic close_out();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence: reset for three cycles, then each scenario in turn.
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_sfifo();
    t_lanes();
    t_force();
    t_step();
    t_modes();
    close_out();
  end
endmodule // scsi_dma_chip_test_regs_tb_top

`default_nettype wire
